// ---- core/sal_cfg.svh ----
`ifndef SAL_CFG_SVH
`define SAL_CFG_SVH

// ==========================================
// register indices (byte address = index * 4)
`define SAL_BCTL_IDX        8'h00
`define SAL_LEDC_IDX        8'h1E
`define SAL_STAT_IDX        8'h20

// ==========================================
// field positions
`define SAL_BCTL_SPEED_BIT  13
`define SAL_BCTL_ANEG_BIT   12
`define SAL_BCTL_ISO_BIT    10
`define SAL_LEDC_MODE_HI    15
`define SAL_LEDC_MODE_LO    14
`define SAL_STAT_ADDR_HI    4
`define SAL_STAT_ADDR_LO    0
`define SAL_STAT_CFG_HI     10
`define SAL_STAT_CFG_LO     8
`define SAL_STAT_RMII_BIT   12

// ==========================================
// reset values and codes
`define SAL_LED_MODE_RST    2'h0
`define SAL_ADDR_TOP_ZERO   2'h0
`define SAL_CFG_RMII        3'h1

// ==========================================
// sampled pin positions in the synchronised vector
`define SAL_PIN_ADDR0       0
`define SAL_PIN_ADDR2       2
`define SAL_PIN_CFG0        3
`define SAL_PIN_CFG2        5
`define SAL_PIN_ISO         6
`define SAL_PIN_SPEED_LED   7
`define SAL_PIN_LINK_LED    8
`define SAL_RUN_PINS        7
`define SAL_SYNC_PINS       9

// ==========================================
// timing
`define SAL_CLK_PERIOD_NS   25
`define SAL_BLINK_HALF_MS   40
`define SAL_BLINK_CYCLES    ((`SAL_BLINK_HALF_MS * 1000000) / `SAL_CLK_PERIOD_NS)

`endif

// ---- core/sal_pkg.sv ----
package sal_pkg;

   typedef enum logic [1:0] {
      SAL_LED_SPEED_LINK,
      SAL_LED_ACTIVITY_LINK,
      SAL_LED_RSVD2,
      SAL_LED_RSVD3
   } sal_led_mode_t;

   typedef struct packed {
      logic [4:0]  mgmtAddr;
      logic [2:0]  cfgCode;
      logic        rmiiMode;
      logic        speedCtl;
      logic        anegCtl;
      logic        isoCtl;
      logic [1:0]  ledMode;
      logic [6:0]  pinOut;
      logic        pinOe;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } sal_top_state_t;

   typedef struct packed {
      logic [31:0] blinkCnt;
      logic        blinkPhase;
      logic        speedLed;
      logic        linkLed;
      logic        ledOe;
   } sal_led_state_t;

   function automatic logic [11:0] sal_byte_addr(input logic [7:0] idx);
      return {2'h0, idx, 2'h0};
   endfunction

endpackage

// ---- core/sal_led_if.sv ----
interface sal_led_if;
   logic [1:0] ledMode;
   logic       linkUp;
   logic       speed100;
   logic       activity;
   logic       speedLed;
   logic       linkLed;
   logic       ledOe;

   modport ctrl (
      output ledMode,
      output linkUp,
      output speed100,
      output activity,
      input  speedLed,
      input  linkLed,
      input  ledOe
   );

   modport drv (
      input  ledMode,
      input  linkUp,
      input  speed100,
      input  activity,
      output speedLed,
      output linkLed,
      output ledOe
   );
endinterface

// ---- core/sal_pin_sync.sv ----
module sal_pin_sync #(
   parameter int W = 9
) (
   input  wire logic         mclk,
   input  wire logic [W-1:0] pinIn,
   output logic      [W-1:0] pinSync
);
   // ==========================================
   // two-stage synchroniser, left unreset so it samples during reset
   logic [W-1:0] stage1_reg;
   logic [W-1:0] stage2_reg;

   always_ff @(posedge mclk) begin
      stage1_reg <= pinIn;
      stage2_reg <= stage1_reg;
   end

   assign pinSync = stage2_reg;
endmodule

// ---- core/sal_led_drive.sv ----
`include "sal_cfg.svh"

module sal_led_drive #(
   parameter int BLINK_CYCLES = `SAL_BLINK_CYCLES
) (
   input  wire logic mclk,
   input  wire logic nrst,
   sal_led_if.drv    led
);
   sal_pkg::sal_led_state_t state_reg;
   sal_pkg::sal_led_state_t state_next;
   logic                    tick;

   // ==========================================
   // blink divider and pin levels
   always_comb begin
      state_next = state_reg;
      tick = (state_reg.blinkCnt == 32'(BLINK_CYCLES - 1));
      state_next.blinkCnt = tick ? 32'h0 : state_reg.blinkCnt + 32'h1;
      if (!led.activity) begin
         state_next.blinkPhase = 1'b0;
      end else if (tick) begin
         state_next.blinkPhase = ~state_reg.blinkPhase;
      end
      state_next.ledOe = 1'b1;
      unique case (sal_pkg::sal_led_mode_t'(led.ledMode))
         sal_pkg::SAL_LED_SPEED_LINK: begin
            state_next.speedLed = ~led.speed100;
            state_next.linkLed  = !led.linkUp ? 1'b1 :
                                  (led.activity ? state_reg.blinkPhase : 1'b0);
         end
         sal_pkg::SAL_LED_ACTIVITY_LINK: begin
            state_next.speedLed = led.activity ? ~state_reg.blinkPhase : 1'b1;
            state_next.linkLed  = ~led.linkUp;
         end
         sal_pkg::SAL_LED_RSVD2,
         sal_pkg::SAL_LED_RSVD3: begin
            state_next.speedLed = 1'b1;
            state_next.linkLed  = 1'b1;
         end
      endcase
      if (!nrst) begin
         // pins float as strap inputs while reset is held
         state_next = '0;
         state_next.speedLed = 1'b1;
         state_next.linkLed  = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      state_reg <= state_next;
   end

   assign led.speedLed = state_reg.speedLed;
   assign led.linkLed  = state_reg.linkLed;
   assign led.ledOe    = state_reg.ledOe;
endmodule

// ---- core/sal_strap_led_ctrl.sv ----
`include "sal_cfg.svh"

// Summary of operation
// - speed/activity LED follows LED mode: speed in 00, activity blink in 01.
// - link/activity LED follows LED mode: link plus blink in 00, link in 01.
// - speed/activity LED pin level at reset loads speed select, control bit 13.
// - chip reset is active low; straps re-captured while it is held.
// - strap pins are sampled in reset, then driven as normal outputs.
// - low three management address bits come from three address straps.
// - default pulls give management address 00001.
// - top two management address bits always read zero.
// - three-bit interface strap latched; 001 means RMII, others reserved.
// - isolate strap latched into control bit 10; high enables isolation.
// - link/activity LED strap latched into control bit 12 as auto-negotiation.
module sal_strap_led_ctrl #(
   parameter int BLINK_CYCLES = `SAL_BLINK_CYCLES
) (
   input  wire logic        mclk,
   input  wire logic        nrst,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // link state from the transceiver core
   input  wire logic        linkUp,
   input  wire logic        speed100,
   input  wire logic        activity,
   // run-time levels for the shared strap pins
   input  wire logic [6:0]  runPinData,
   // shared strap pins: addr2..0, config2..0, isolate
   input  wire logic [6:0]  strapPinIn,
   output logic      [6:0]  strapPinOut,
   output logic      [6:0]  strapPinOe,
   // led pins
   input  wire logic        speedActivityIndicatorIn,
   output logic             speedActivityIndicatorOut,
   output logic             speedActivityIndicatorOe,
   input  wire logic        linkActivityIndicatorIn,
   output logic             linkActivityIndicatorOut,
   output logic             linkActivityIndicatorOe,
   // captured configuration
   output logic      [4:0]  mgmtAddr,
   output logic      [2:0]  ifaceCfg,
   output logic             rmiiMode,
   output logic             ctrlSpeed100,
   output logic             ctrlAutoneg,
   output logic             ctrlIsolate
);
   sal_pkg::sal_top_state_t        state_reg;
   sal_pkg::sal_top_state_t        state_next;
   logic [`SAL_SYNC_PINS-1:0]      pinSync;
   logic [31:0]                    readVal;
   logic                           hit;
   logic                           accessNew;
   logic                           accessDone;

   sal_led_if ledBus ();

   // ==========================================
   // pin synchronisers
   sal_pin_sync #(
      .W (`SAL_SYNC_PINS)
   ) u_sync (
      .mclk    (mclk),
      .pinIn   ({linkActivityIndicatorIn, speedActivityIndicatorIn, strapPinIn}),
      .pinSync (pinSync)
   );

   // ==========================================
   // led drivers
   assign ledBus.ledMode  = state_reg.ledMode;
   assign ledBus.linkUp   = linkUp;
   assign ledBus.speed100 = speed100;
   assign ledBus.activity = activity;

   sal_led_drive #(
      .BLINK_CYCLES (BLINK_CYCLES)
   ) u_led (
      .mclk (mclk),
      .nrst (nrst),
      .led  (ledBus.drv)
   );

   // ==========================================
   // register read decode
   always_comb begin
      readVal = 32'h0;
      hit     = 1'b1;
      if (paddr == sal_pkg::sal_byte_addr(`SAL_BCTL_IDX)) begin
         readVal[`SAL_BCTL_SPEED_BIT] = state_reg.speedCtl;
         readVal[`SAL_BCTL_ANEG_BIT]  = state_reg.anegCtl;
         readVal[`SAL_BCTL_ISO_BIT]   = state_reg.isoCtl;
      end else if (paddr == sal_pkg::sal_byte_addr(`SAL_LEDC_IDX)) begin
         readVal[`SAL_LEDC_MODE_HI:`SAL_LEDC_MODE_LO] = state_reg.ledMode;
      end else if (paddr == sal_pkg::sal_byte_addr(`SAL_STAT_IDX)) begin
         readVal[`SAL_STAT_ADDR_HI:`SAL_STAT_ADDR_LO] = state_reg.mgmtAddr;
         readVal[`SAL_STAT_CFG_HI:`SAL_STAT_CFG_LO]   = state_reg.cfgCode;
         readVal[`SAL_STAT_RMII_BIT]                  = state_reg.rmiiMode;
      end else begin
         hit = 1'b0;
      end
   end

   assign accessNew  = psel && penable && !state_reg.pready;
   assign accessDone = psel && penable && state_reg.pready;

   // ==========================================
   // next state
   always_comb begin
      state_next = state_reg;
      if (!nrst) begin
         // strap capture repeats every cycle reset is low
         state_next.mgmtAddr = {`SAL_ADDR_TOP_ZERO,
                                pinSync[`SAL_PIN_ADDR2:`SAL_PIN_ADDR0]};
         state_next.cfgCode  = pinSync[`SAL_PIN_CFG2:`SAL_PIN_CFG0];
         state_next.rmiiMode = (pinSync[`SAL_PIN_CFG2:`SAL_PIN_CFG0]
                                == `SAL_CFG_RMII);
         state_next.isoCtl   = pinSync[`SAL_PIN_ISO];
         state_next.speedCtl = pinSync[`SAL_PIN_SPEED_LED];
         state_next.anegCtl  = pinSync[`SAL_PIN_LINK_LED];
         state_next.ledMode  = `SAL_LED_MODE_RST;
         state_next.pinOut   = 7'h00;
         state_next.pinOe    = 1'b0;
         state_next.pready   = 1'b0;
         state_next.pslverr  = 1'b0;
         state_next.prdata   = 32'h0;
      end else begin
         // captured address and config straps untouched here until next reset; speed, auto-neg and isolate bits writable over apb
         state_next.pinOe  = 1'b1;
         state_next.pinOut = runPinData;
         state_next.pready = accessNew;
         if (accessNew) begin
            state_next.pslverr = !hit;
            state_next.prdata  = (pwrite || !hit) ? 32'h0 : readVal;
         end else if (accessDone) begin
            state_next.pslverr = 1'b0;
         end
         if (accessDone && pwrite && pstrb[1]) begin
            if (paddr == sal_pkg::sal_byte_addr(`SAL_BCTL_IDX)) begin
               state_next.speedCtl = pwdata[`SAL_BCTL_SPEED_BIT];
               state_next.anegCtl  = pwdata[`SAL_BCTL_ANEG_BIT];
               state_next.isoCtl   = pwdata[`SAL_BCTL_ISO_BIT];
            end else if (paddr == sal_pkg::sal_byte_addr(`SAL_LEDC_IDX)) begin
               state_next.ledMode = pwdata[`SAL_LEDC_MODE_HI:`SAL_LEDC_MODE_LO];
            end
         end
      end
   end

   always_ff @(posedge mclk) begin
      state_reg <= state_next;
   end

   // ==========================================
   // outputs, all from flip-flops
   assign prdata                    = state_reg.prdata;
   assign pready                    = state_reg.pready;
   assign pslverr                   = state_reg.pslverr;
   assign strapPinOut               = state_reg.pinOut;
   assign strapPinOe                = {7{state_reg.pinOe}};
   assign speedActivityIndicatorOut = ledBus.speedLed;
   assign speedActivityIndicatorOe  = ledBus.ledOe;
   assign linkActivityIndicatorOut  = ledBus.linkLed;
   assign linkActivityIndicatorOe   = ledBus.ledOe;
   assign mgmtAddr                  = state_reg.mgmtAddr;
   assign ifaceCfg                  = state_reg.cfgCode;
   assign rmiiMode                  = state_reg.rmiiMode;
   assign ctrlSpeed100              = state_reg.speedCtl;
   assign ctrlAutoneg               = state_reg.anegCtl;
   assign ctrlIsolate               = state_reg.isoCtl;
endmodule

// ---- testbench/sal_board_model.sv ----
module sal_board_model (
   input  wire logic [8:0] straps,
   input  wire logic [6:0] strapPinOut,
   input  wire logic [6:0] strapPinOe,
   input  wire logic       speedActivityIndicatorOut,
   input  wire logic       speedActivityIndicatorOe,
   input  wire logic       linkActivityIndicatorOut,
   input  wire logic       linkActivityIndicatorOe,
   output logic      [6:0] strapPinIn,
   output logic            speedActivityIndicatorIn,
   output logic            linkActivityIndicatorIn
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================
   // released pins settle to the board pulls
   always_comb begin
      for (int i = 0; i < 7; i++) begin
         strapPinIn[i] = strapPinOe[i] ? strapPinOut[i] : straps[i];
      end
      speedActivityIndicatorIn = speedActivityIndicatorOe ? speedActivityIndicatorOut : straps[7];
      linkActivityIndicatorIn = linkActivityIndicatorOe ? linkActivityIndicatorOut : straps[8];
   end
endmodule

// ---- testbench/sal_strap_led_checker.sv ----
module sal_strap_led_checker (
   input wire logic        mclk,
   input wire logic        nrst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pready,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic        linkUp,
   input wire logic        speed100,
   input wire logic [6:0]  runPinData,
   input wire logic [6:0]  strapPinOut,
   input wire logic [6:0]  strapPinOe,
   input wire logic        speedActivityIndicatorOut,
   input wire logic        speedActivityIndicatorOe,
   input wire logic        linkActivityIndicatorOut,
   input wire logic        linkActivityIndicatorOe,
   input wire logic [4:0]  mgmtAddr,
   input wire logic [2:0]  ifaceCfg,
   input wire logic        rmiiMode
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================
   // shadow of the led mode field
   logic [1:0] mode_reg;
   logic [1:0] mode_next;
   always_comb begin
      mode_next = mode_reg;
      if (psel && penable && pready && pwrite && pstrb[1] && paddr == 12'h078) begin
         mode_next = pwdata[15:14];
      end
      if (!nrst) begin
         mode_next = 2'h0;
      end
   end
   always_ff @(posedge mclk) begin
      mode_reg <= mode_next;
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   // ==========================================
   // properties
   property p_top; mgmtAddr[4:3] == 2'h0; endproperty
   a_top: assert property (p_top) else $error("address top bits set");
   property p_hold; $past(nrst) |-> $stable({mgmtAddr, ifaceCfg}); endproperty
   a_hold: assert property (p_hold) else $error("strap value moved");
   property p_rmii; rmiiMode == (ifaceCfg == 3'h1); endproperty
   a_rmii: assert property (p_rmii) else $error("rmii flag wrong");
   property p_rstoe; disable iff (1'b0) !$past(nrst)
      |-> strapPinOe == 7'h00 && !speedActivityIndicatorOe && !linkActivityIndicatorOe;
   endproperty
   a_rstoe: assert property (p_rstoe) else $error("pins driven in reset");
   property p_runoe; $past(nrst)
      |-> &strapPinOe && speedActivityIndicatorOe && linkActivityIndicatorOe; endproperty
   a_runoe: assert property (p_runoe) else $error("pins not driven");
   property p_pin; $past(nrst) |-> strapPinOut == $past(runPinData); endproperty
   a_pin: assert property (p_pin) else $error("pin level wrong");
   property p_spd; $past(nrst) && $past(mode_reg) == 2'h0
      |-> speedActivityIndicatorOut == !$past(speed100); endproperty
   a_spd: assert property (p_spd) else $error("speed led wrong");
   property p_off; $past(nrst) && $past(mode_reg[1])
      |-> speedActivityIndicatorOut && linkActivityIndicatorOut; endproperty
   a_off: assert property (p_off) else $error("reserved mode lit");
   property p_lnk; $past(nrst) && $past(mode_reg) == 2'h1
      |-> linkActivityIndicatorOut == !$past(linkUp); endproperty
   a_lnk: assert property (p_lnk) else $error("link led wrong");
endmodule

bind sal_strap_led_ctrl sal_strap_led_checker u_chk (.*);

// ---- testbench/testbench.sv ----
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk = 1'b0;
   logic        nrst = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0]  pstrb = 4'hF;
   logic        linkUp = 1'b0;
   logic        speed100 = 1'b0;
   logic        activity = 1'b0;
   logic [6:0]  runPinData = 7'h00;
   logic [8:0]  straps = 9'h181;
   logic [31:0] prdata, r;
   logic        pready, pslverr, e, pin;
   logic [6:0]  strapPinIn, strapPinOut, strapPinOe;
   logic        speedActivityIndicatorIn, speedActivityIndicatorOut, speedActivityIndicatorOe;
   logic        linkActivityIndicatorIn, linkActivityIndicatorOut, linkActivityIndicatorOe;
   logic [4:0]  mgmtAddr;
   logic [2:0]  ifaceCfg;
   logic        rmiiMode, ctrlSpeed100, ctrlAutoneg, ctrlIsolate;
   int          fail_count = 0;
   int          checks_done = 0;
   int          n0, n1;

   always #12.5 mclk = ~mclk;
   sal_strap_led_ctrl #(.BLINK_CYCLES(4)) dut (.*);
   sal_board_model board (.*);

   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      checks_done++;
      if (g !== x) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", n, x, g);
      end
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         fail_count++;
         end_sim();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic strap_test(input logic [8:0] s);
      nrst <= 1'b0;
      straps <= s;
      repeat (12) @(posedge mclk);
      nrst <= 1'b1;
      runPinData <= ~s[6:0];
      @(posedge mclk);
      chk("addr", 32'({2'h0, s[2:0]}), 32'(mgmtAddr));
      chk("cfg", 32'({s[5:3] == 3'h1, s[5:3]}), 32'({rmiiMode, ifaceCfg}));
      chk("ctl", 32'({s[7], s[8], s[6]}), 32'({ctrlSpeed100, ctrlAutoneg, ctrlIsolate}));
      apb(1'b0, 12'h000, 32'h0);
      chk("ctlreg", 32'({s[7], s[8], 1'b0, s[6]}) << 10, r);
      apb(1'b0, 12'h080, 32'h0);
      chk("status", 32'({s[5:3] == 3'h1, 1'b0, s[5:3], 5'h00, s[2:0]}), r);
      chk("pins", 32'({7'h7F, ~s[6:0]}), 32'({strapPinOe, strapPinOut}));
      chk("hold", 32'({s[5:3], s[2:0]}), 32'({ifaceCfg, mgmtAddr[2:0]}));
      $display("test straps %h done", s);
   endtask

   initial begin
      strap_test(9'h181);
      strap_test(9'h04F);
      strap_test(9'h1B8);
      for (int m = 0; m < 4; m++) begin
         apb(1'b1, 12'h078, 32'(m) << 14);
         for (int v = 0; v < 4; v++) begin
            {linkUp, speed100} <= v[1:0];
            repeat (2) @(posedge mclk);
            chk("leds", m[1] ? 2'h3 : m[0] ? {1'b1, ~v[1]} : {~v[0], ~v[1]},
                {speedActivityIndicatorOut, linkActivityIndicatorOut});
         end
         activity <= 1'b1;
         linkUp <= 1'b1;
         n0 = 0;
         n1 = 0;
         repeat (12) begin
            @(posedge mclk);
            pin = m[0] ? speedActivityIndicatorOut : linkActivityIndicatorOut;
            n0 += int'(pin === 1'b0);
            n1 += int'(pin === 1'b1);
         end
         chk("blink", 32'(!m[1]), 32'(n0 > 0 && n1 > 0));
         activity <= 1'b0;
         $display("test led mode %0d done", m);
      end
      pstrb <= 4'hD;
      apb(1'b1, 12'h078, 32'h0);
      pstrb <= 4'hF;
      apb(1'b0, 12'h078, 32'h0);
      chk("strobe", 32'h0000C000, r);
      $display("test strobe done");
      apb(1'b0, 12'h100, 32'h0);
      chk("unmaperr", 32'h1, 32'(e));
      chk("unmapdata", 32'h0, r);
      $display("test unmapped done");
      end_sim();
   end
endmodule
